// file: inc/dtm_pkg.sv
// Package of constants for the dual 16/32-bit timer block
// Operation
// - Cascaded, first timer is low word, second timer is high word.
// - Cascaded, second control register ignored; first control and pins used.
// - Cascaded, interrupt goes through second timer flag and enable.
// - Split, each timer runs alone, internal or synced external, never async.
// - First timer resynchronises prescaler output; second timer also has no gate mode.
// - 32-bit timer mode counts each cycle to combined period, reloads zero.
// - Reading low count latches high count into holding register.
// - Write holding then low count; holding moves into high count.
// - 32-bit counter mode counts synced external rising edges to period.
// - Idle stops the timer when stop-in-idle is one, else it runs.
// - Gate mode needs timer on and internal clock; counts while gate high.
// - Second timer ignores gate enable; gated 32-bit clock from first timer.
// - Gate falling edge stops counting, keeps count until software clears.
// - 32-bit period match pulses the ADC trigger from second timer.
// - Prescale 1, 8, 64 or 256 chosen by control bits 5 to 4.
// - In 32-bit mode only the first timer prescaler is used.
// - Prescaler cleared on count write, timer-on clear, or reset.
// - First prescaler is not reset while its timer is off.
// - Writing control leaves the count unchanged.
// - During sleep the timers do not count.
// - Period match or gate fall sets second timer flag, bit 7.
// - 16-bit timer mode counts each cycle to own period, reloads zero.
package dtm_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_LOW_CNT = 12'h106;
    localparam logic [11:0] OFS_HOLD = 12'h108;
    localparam logic [11:0] OFS_HIGH_CNT = 12'h10a;
    localparam logic [11:0] OFS_LOW_PER = 12'h10c;
    localparam logic [11:0] OFS_HIGH_PER = 12'h10e;
    localparam logic [11:0] OFS_CTL1 = 12'h110;
    localparam logic [11:0] OFS_CTL2 = 12'h112;
    // Interrupt flag/enable register of own choosing
    localparam logic [11:0] OFS_IRQ = 12'h114;
    localparam logic [15:0] RST_PER = 16'hffff;
    localparam logic [15:0] RST_CTL = 16'h0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam int BIT_ON = 15;
    localparam int BIT_SIDL = 13;
    localparam int BIT_GATE = 6;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_CASC = 3;
    localparam int BIT_CS = 1;
    localparam logic [15:0] CTL1_MASK = 16'ha07a;
    localparam logic [15:0] CTL2_MASK = 16'ha072;
    // Irq register: flag at bit 7, enable at bit 15
    localparam int BIT_IRQ_FLAG = 7;
    localparam int BIT_IRQ_EN = 15;
    localparam int PS_W = 8;
    localparam logic [7:0] PS_DIV1 = 8'h00;
    localparam logic [7:0] PS_DIV8 = 8'h07;
    localparam logic [7:0] PS_DIV64 = 8'h3f;
    localparam logic [7:0] PS_DIV256 = 8'hff;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {DTM_IDLE, DTM_ACK} dtm_bus_e;
endpackage

// file: src/dtm_prescaler.sv
// Prescaler for one timer: divides the selected count clock
`timescale 1ns/1ns
`default_nettype none
module dtm_prescaler
    import dtm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tick_in,
    input wire logic [1:0] sel,
    input wire logic clr,
    input wire logic sync_out,
    output logic tick_out
);
    logic [PS_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [PS_W-1:0] lim;
    logic raw;

    // Terminal count per division setting
    always_comb begin
        case (sel)
            2'd0: lim = PS_DIV1;
            2'd1: lim = PS_DIV8;
            2'd2: lim = PS_DIV64;
            default: lim = PS_DIV256;
        endcase
        raw = tick_in && (cnt_q == lim);
        cnt_d = cnt_q;
        if (clr) begin
            cnt_d = '0;
        end else if (tick_in) begin
            cnt_d = raw ? '0 : cnt_q + 1'b1;
        end
        tick_d = raw;
    end

    // Count register and optional resync stage
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    // First timer uses the resynchronised tick
    assign tick_out = sync_out ? tick_q : raw;
endmodule
`default_nettype wire

// file: src/dtm_timer.sv
// Dual 16-bit or cascaded 32-bit timer with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
module dtm_timer
    import dtm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [dtm_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_response_err,
    input wire logic ext_clock_gate_pin,
    input wire logic ext_clock_pin2,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    output logic irq,
    output logic adc_trigger
);
    import dtm_pkg::*;

    // ****************************************
    // Register state
    // ****************************************
    logic [15:0] cnt1_q, cnt1_d, cnt2_q, cnt2_d;
    logic [15:0] hold_q, hold_d, per1_q, per1_d, per2_q, per2_d;
    logic [15:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d;
    logic flag_q, flag_d, en_q, en_d;
    logic irq_q, irq_d, adc_q, adc_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d, wait_q, wait_d;
    dtm_bus_e st_q, st_d;
    logic [1:0] pin1_q, pin1_d;
    logic [2:0] pin2_q, pin2_d;
    logic gate_q, gate_d;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // Bus access strobes
    // ****************************************
    logic acc, wr, rd;
    logic wr_c1, wr_c2, wr_hold, wr_ctl1, wr_ctl2, rd_c1;
    logic [15:0] wval;
    always_comb begin
        acc = (st_q == DTM_IDLE) && (avs_read || avs_write);
        wr = acc && avs_write;
        rd = acc && avs_read;
        wr_c1 = wr && hit(avs_address, OFS_LOW_CNT);
        wr_c2 = wr && hit(avs_address, OFS_HIGH_CNT);
        wr_hold = wr && hit(avs_address, OFS_HOLD);
        wr_ctl1 = wr && hit(avs_address, OFS_CTL1);
        wr_ctl2 = wr && hit(avs_address, OFS_CTL2);
        rd_c1 = rd && hit(avs_address, OFS_LOW_CNT);
        wval = avs_writedata[15:0];
    end

    // ****************************************
    // Mode and clock selection
    // ****************************************
    logic casc, on1, on2, run1, run2, gate_en1, gate_en2;
    logic sync1, sync2, edge1, edge2, gate_fall;
    logic src1, src2, ps_tick1, ps_tick2, inc1, inc2;
    logic clr_ps1, clr_ps2;
    always_comb begin
        casc = ctl1_q[BIT_CASC];
        on1 = ctl1_q[BIT_ON];
        // Second control ignored when cascaded
        on2 = casc ? 1'b0 : ctl2_q[BIT_ON];
        // Sleep halts all counting; idle halts if stop-in-idle set
        run1 = on1 && !cpu_sleep && !(cpu_idle && ctl1_q[BIT_SIDL]);
        run2 = on2 && !cpu_sleep && !(cpu_idle && ctl2_q[BIT_SIDL]);
        sync1 = pin1_q[1];
        sync2 = pin2_q[1];
        edge1 = sync1 && !gate_q;
        edge2 = sync2 && !pin2_q[2];
        gate_en1 = ctl1_q[BIT_GATE] && !ctl1_q[BIT_CS];
        gate_en2 = 1'b0;
        gate_fall = on1 && gate_en1 && gate_q && !sync1;
        // Count source: external sync edge or instruction cycle
        if (ctl1_q[BIT_CS]) begin
            src1 = run1 && edge1;
        end else begin
            src1 = run1 && (!gate_en1 || sync1);
        end
        if (ctl2_q[BIT_CS]) begin
            src2 = run2 && edge2 && !gate_en2;
        end else begin
            src2 = run2;
        end
        clr_ps1 = wr_c1 || wr_c2 || (wr_ctl1 && on1 && !wval[BIT_ON]);
        clr_ps2 = wr_c2 || (wr_ctl2 && ctl2_q[BIT_ON] && !wval[BIT_ON]);
    end

    // Prescaler of first timer, resynchronised; unused when off
    dtm_prescaler u_ps1 (
        .clk(clk),
        .rst(rst),
        .tick_in(src1),
        .sel(ctl1_q[BIT_PS_HI:BIT_PS_LO]),
        .clr(clr_ps1 && on1),
        .sync_out(1'b1),
        .tick_out(ps_tick1)
    );

    // Prescaler of second timer, no resync; idle when cascaded
    dtm_prescaler u_ps2 (
        .clk(clk),
        .rst(rst),
        .tick_in(src2),
        .sel(ctl2_q[BIT_PS_HI:BIT_PS_LO]),
        .clr(clr_ps2),
        .sync_out(1'b0),
        .tick_out(ps_tick2)
    );

    // ****************************************
    // Counters, period match and events
    // ****************************************
    logic match16_1, match16_2, match32;
    always_comb begin
        inc1 = ps_tick1 && run1;
        inc2 = ps_tick2 && run2;
        match16_1 = (cnt1_q == per1_q);
        match16_2 = (cnt2_q == per2_q);
        match32 = match16_1 && match16_2;
        cnt1_d = cnt1_q;
        cnt2_d = cnt2_q;
        if (casc) begin
            if (inc1) begin
                if (match32) begin
                    cnt1_d = RST_CNT;
                    cnt2_d = RST_CNT;
                end else begin
                    cnt1_d = cnt1_q + 16'h0001;
                    cnt2_d = (cnt1_q == 16'hffff) ? cnt2_q + 16'h0001 : cnt2_q;
                end
            end
        end else begin
            if (inc1) begin
                cnt1_d = match16_1 ? RST_CNT : cnt1_q + 16'h0001;
            end
            if (inc2) begin
                cnt2_d = match16_2 ? RST_CNT : cnt2_q + 16'h0001;
            end
        end
        // Software writes win over counting; control write leaves counts
        if (wr_c1) begin
            cnt1_d = merge(cnt1_q, avs_writedata, avs_byteenable);
            if (casc) begin
                cnt2_d = hold_q;
            end
        end
        if (wr_c2) begin
            cnt2_d = merge(cnt2_q, avs_writedata, avs_byteenable);
        end
        // Match event only when cascaded counter actually advances
        adc_d = casc && inc1 && match32;
        gate_d = sync1;
        pin1_d = {pin1_q[0], ext_clock_gate_pin};
        pin2_d = {pin2_q[1:0], ext_clock_pin2};
    end

    // ****************************************
    // Register writes, interrupt flag
    // ****************************************
    logic flag_set;
    always_comb begin
        hold_d = hold_q;
        per1_d = per1_q;
        per2_d = per2_q;
        ctl1_d = ctl1_q;
        ctl2_d = ctl2_q;
        flag_d = flag_q;
        en_d = en_q;
        if (rd_c1) begin
            hold_d = cnt2_q;
        end else if (wr_hold) begin
            hold_d = merge(hold_q, avs_writedata, avs_byteenable);
        end
        if (wr && hit(avs_address, OFS_LOW_PER)) begin
            per1_d = merge(per1_q, avs_writedata, avs_byteenable);
        end
        if (wr && hit(avs_address, OFS_HIGH_PER)) begin
            per2_d = merge(per2_q, avs_writedata, avs_byteenable);
        end
        if (wr_ctl1) begin
            ctl1_d = merge(ctl1_q, avs_writedata, avs_byteenable) & CTL1_MASK;
        end
        if (wr_ctl2) begin
            ctl2_d = merge(ctl2_q, avs_writedata, avs_byteenable) & CTL2_MASK;
        end
        if (wr && hit(avs_address, OFS_IRQ)) begin
            if (avs_byteenable[0]) begin
                flag_d = avs_writedata[BIT_IRQ_FLAG];
            end
            if (avs_byteenable[1]) begin
                en_d = avs_writedata[BIT_IRQ_EN];
            end
        end
        // Second timer flag: 32-bit match, gate fall, or own 16-bit match
        flag_set = (casc && inc1 && match32) || gate_fall
            || (!casc && inc2 && match16_2);
        if (flag_set) begin
            flag_d = 1'b1;
        end
        irq_d = flag_d && en_d;
    end

    // ****************************************
    // Avalon-MM answer: one wait cycle, then data
    // ****************************************
    always_comb begin
        st_d = st_q;
        rdata_d = rdata_q;
        err_d = err_q;
        case (st_q)
            DTM_IDLE: begin
                if (acc) begin
                    st_d = DTM_ACK;
                    err_d = 1'b0;
                    rdata_d = DATA_ZERO;
                    if (hit(avs_address, OFS_LOW_CNT)) begin
                        rdata_d[15:0] = cnt1_q;
                    end else if (hit(avs_address, OFS_HOLD)) begin
                        rdata_d[15:0] = hold_q;
                    end else if (hit(avs_address, OFS_HIGH_CNT)) begin
                        rdata_d[15:0] = cnt2_q;
                    end else if (hit(avs_address, OFS_LOW_PER)) begin
                        rdata_d[15:0] = per1_q;
                    end else if (hit(avs_address, OFS_HIGH_PER)) begin
                        rdata_d[15:0] = per2_q;
                    end else if (hit(avs_address, OFS_CTL1)) begin
                        rdata_d[15:0] = ctl1_q;
                    end else if (hit(avs_address, OFS_CTL2)) begin
                        rdata_d[15:0] = ctl2_q;
                    end else if (hit(avs_address, OFS_IRQ)) begin
                        rdata_d[BIT_IRQ_FLAG] = flag_q;
                        rdata_d[BIT_IRQ_EN] = en_q;
                    end else begin
                        err_d = 1'b1;
                    end
                end
            end
            default: begin
                st_d = DTM_IDLE;
            end
        endcase
        wait_d = (st_d == DTM_IDLE);
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt1_q <= RST_CNT;
            cnt2_q <= RST_CNT;
            hold_q <= RST_CNT;
            per1_q <= RST_PER;
            per2_q <= RST_PER;
            ctl1_q <= RST_CTL;
            ctl2_q <= RST_CTL;
            flag_q <= 1'b0;
            en_q <= 1'b0;
            irq_q <= 1'b0;
            adc_q <= 1'b0;
            rdata_q <= DATA_ZERO;
            err_q <= 1'b0;
            st_q <= DTM_IDLE;
            wait_q <= 1'b1;
            pin1_q <= 2'b00;
            pin2_q <= 3'b000;
            gate_q <= 1'b0;
        end else begin
            cnt1_q <= cnt1_d;
            cnt2_q <= cnt2_d;
            hold_q <= hold_d;
            per1_q <= per1_d;
            per2_q <= per2_d;
            ctl1_q <= ctl1_d;
            ctl2_q <= ctl2_d;
            flag_q <= flag_d;
            en_q <= en_d;
            irq_q <= irq_d;
            adc_q <= adc_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            st_q <= st_d;
            wait_q <= wait_d;
            pin1_q <= pin1_d;
            pin2_q <= pin2_d;
            gate_q <= gate_d;
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        avs_readdata = rdata_q;
        avs_response_err = err_q;
        avs_waitrequest = wait_q;
        irq = irq_q;
        adc_trigger = adc_q;
    end
endmodule
`default_nettype wire

// file: verif/dtm_timer_chk.sv
// Checker of bus handshake and event outputs of the dual timer
`timescale 1ns/1ns
`default_nettype none
module dtm_timer_chk
    import dtm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [dtm_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_response_err,
    input wire logic ext_clock_gate_pin,
    input wire logic ext_clock_pin2,
    input wire logic cpu_idle,
    input wire logic cpu_sleep,
    input wire logic irq,
    input wire logic adc_trigger
);
    // ****************
    // Address decode
    // ****************
    function automatic logic mapped(input logic [11:0] a);
        return a inside {OFS_LOW_CNT, OFS_HOLD, OFS_HIGH_CNT, OFS_LOW_PER,
            OFS_HIGH_PER, OFS_CTL1, OFS_CTL2, OFS_IRQ};
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Request taken, then a single answer cycle
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_ANSWER: assert property (s_take |=> s_answer)
        else $error("answer not one cycle after request");
    AST_NO_SPURIOUS: assert property (
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    AST_ERR_MAP: assert property (
        !avs_waitrequest |-> avs_response_err == !mapped($past(avs_address)))
        else $error("error response does not match address");
    AST_ERR_ZERO: assert property (
        avs_response_err && !avs_waitrequest && $past(avs_read)
        |-> avs_readdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    AST_UPPER_ZERO: assert property (
        !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    AST_ADC_PULSE: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    AST_IRQ_FALL: assert property ($fell(irq) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("interrupt cleared without software write");
    AST_SLEEP: assert property (cpu_sleep [*4] |-> !adc_trigger)
        else $error("trigger during sleep");
endmodule
bind dtm_timer dtm_timer_chk dtm_timer_chk_i (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response_err(avs_response_err),
    .ext_clock_gate_pin(ext_clock_gate_pin), .ext_clock_pin2(ext_clock_pin2),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq),
    .adc_trigger(adc_trigger));
`default_nettype wire

// file: verif/tb.sv
// Self-checking testbench of the dual 16/32-bit timer
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dtm_pkg::*;
    logic clk, rst, rd, wr, gpin, pin2, idle, slp, wait_rq, err, irq, adc;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, q, q2;
    logic [3:0] be;
    logic e;
    int errors, n_compared, k;
    int sh[4] = '{0, 3, 6, 8};
    dtm_timer dtm_timer_i (.clk(clk), .rst(rst), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
        .avs_response_err(err), .ext_clock_gate_pin(gpin),
        .ext_clock_pin2(pin2), .cpu_idle(idle), .cpu_sleep(slp), .irq(irq),
        .adc_trigger(adc));
    // ****************
    // Clock, tasks
    // ****************
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] s, x);
        n_compared++;
        if (s !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a,
            input logic [15:0] d);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {16'h0000, d};
        do @(posedge clk); while (wait_rq !== 1'b0);
        q = rdata;
        e = err;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wrr(input logic [11:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
            input logic [31:0] x);
        bus(1'b0, a, 16'h0000);
        chk(nm, q, x);
    endtask
    // Two low-count reads, compared for equality
    task automatic two_reads(input string nm, input logic same);
        bus(1'b0, OFS_LOW_CNT, 16'h0000);
        q2 = q;
        bus(1'b0, OFS_LOW_CNT, 16'h0000);
        chk(nm, 32'(q == q2), 32'(same));
    endtask
    // Rising edges on one of the clock pins
    task automatic edges(input logic second, input int n);
        repeat (n) begin
            if (second) pin2 <= 1'b1;
            else gpin <= 1'b1;
            repeat (4) @(posedge clk);
            pin2 <= 1'b0;
            gpin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #160000;
        errors++;
        tally_and_finish();
    end
    // ****************
    // Test sequence
    // ****************
    initial begin
        rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 12'h000; wdata = 32'h0;
        be = 4'h3; gpin = 1'b0; pin2 = 1'b0; idle = 1'b0; slp = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdc("low count", OFS_LOW_CNT, 32'h0);
        rdc("high count", OFS_HIGH_CNT, 32'h0);
        rdc("low period", OFS_LOW_PER, 32'hffff);
        rdc("high period", OFS_HIGH_PER, 32'hffff);
        rdc("control one", OFS_CTL1, 32'h0);
        rdc("control two", OFS_CTL2, 32'h0);
        rdc("unmapped data", 12'h120, 32'h0);
        chk("unmapped err", 32'(e), 32'h1);
        wrr(12'h120, 16'h55aa);
        chk("unmapped write err", 32'(e), 32'h1);
        wrr(OFS_CTL1, 16'hffff);
        rdc("control one mask", OFS_CTL1, {16'h0, CTL1_MASK});
        wrr(OFS_CTL2, 16'hffff);
        rdc("control two mask", OFS_CTL2, {16'h0, CTL2_MASK});
        wrr(OFS_CTL1, 16'h0000);
        wrr(OFS_CTL2, 16'h0000);
        // Coherent 32-bit write and read through the holding register
        wrr(OFS_CTL1, 16'h0008);
        wrr(OFS_HOLD, 16'habcd);
        wrr(OFS_LOW_CNT, 16'h5678);
        wrr(OFS_CTL1, 16'h0010);
        rdc("high after pair", OFS_HIGH_CNT, 32'habcd);
        rdc("low after control", OFS_LOW_CNT, 32'h5678);
        wrr(OFS_HIGH_CNT, 16'h1357);
        rdc("low again", OFS_LOW_CNT, 32'h5678);
        rdc("hold latched", OFS_HOLD, 32'h1357);
        // Cascaded period match with second control off
        wrr(OFS_LOW_PER, 16'h0003);
        wrr(OFS_HIGH_PER, 16'h0001);
        wrr(OFS_IRQ, 16'h8000);
        wrr(OFS_CTL1, 16'h0008);
        wrr(OFS_HOLD, 16'h0001);
        wrr(OFS_LOW_CNT, 16'h0000);
        wrr(OFS_CTL1, 16'h8008);
        k = 0;
        while (adc !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        chk("trigger seen", 32'(k < 100), 32'h1);
        repeat (3) @(posedge clk);
        chk("irq raised", 32'(irq), 32'h1);
        wrr(OFS_CTL1, 16'h0000);
        bus(1'b0, OFS_LOW_CNT, 16'h0000);
        chk("low wrapped", 32'(q < 8), 32'h1);
        rdc("high wrapped", OFS_HOLD, 32'h0);
        repeat (20) @(posedge clk);
        rdc("flag kept", OFS_IRQ, 32'h8080);
        wrr(OFS_IRQ, 16'h8000);
        rdc("flag cleared", OFS_IRQ, 32'h8000);
        chk("irq cleared", 32'(irq), 32'h0);
        // Split mode, sleep and idle
        wrr(OFS_LOW_PER, 16'hffff);
        wrr(OFS_LOW_CNT, 16'h0000);
        wrr(OFS_CTL1, 16'h8000);
        two_reads("split runs", 1'b0);
        slp <= 1'b1;
        repeat (4) @(posedge clk);
        two_reads("sleep holds", 1'b1);
        slp <= 1'b0;
        wrr(OFS_CTL1, 16'ha000);
        idle <= 1'b1;
        repeat (4) @(posedge clk);
        two_reads("idle stops", 1'b1);
        wrr(OFS_CTL1, 16'h8000);
        two_reads("idle runs", 1'b0);
        idle <= 1'b0;
        wrr(OFS_LOW_PER, 16'h0005);
        wrr(OFS_LOW_CNT, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, OFS_LOW_CNT, 16'h0000);
            chk("low within period", 32'(q <= 5), 32'h1);
        end
        rdc("high untouched", OFS_HIGH_CNT, 32'h0);
        // Each prescale setting over 1024 cycles
        wrr(OFS_LOW_PER, 16'hffff);
        for (int s = 0; s < 4; s++) begin
            wrr(OFS_CTL1, 16'h8000 | 16'(s << 4));
            wrr(OFS_LOW_CNT, 16'h0000);
            repeat (1024) @(posedge clk);
            wrr(OFS_CTL1, 16'h0000);
            bus(1'b0, OFS_LOW_CNT, 16'h0000);
            k = 1024 >> sh[s];
            chk("prescaled", 32'(q + 1 >= k && q <= k + 5), 32'h1);
        end
        // Gated accumulation
        wrr(OFS_LOW_CNT, 16'h0000);
        wrr(OFS_CTL1, 16'h8040);
        two_reads("gate closed", 1'b1);
        gpin <= 1'b1;
        repeat (40) @(posedge clk);
        gpin <= 1'b0;
        repeat (10) @(posedge clk);
        two_reads("gate count kept", 1'b1);
        chk("gated count", 32'(q >= 36 && q <= 44), 32'h1);
        rdc("gate flag", OFS_IRQ, 32'h8080);
        // Counter modes: cascaded, then second timer alone
        wrr(OFS_CTL1, 16'h800a);
        wrr(OFS_CTL2, 16'h8000);
        wrr(OFS_HOLD, 16'h0000);
        wrr(OFS_LOW_CNT, 16'h0000);
        edges(1'b0, 5);
        repeat (6) @(posedge clk);
        rdc("counted edges", OFS_LOW_CNT, 32'h5);
        rdc("high ignores", OFS_HOLD, 32'h0);
        wrr(OFS_HIGH_PER, 16'hffff);
        wrr(OFS_CTL1, 16'h0000);
        wrr(OFS_CTL2, 16'h8002);
        wrr(OFS_HIGH_CNT, 16'h0000);
        edges(1'b1, 3);
        repeat (6) @(posedge clk);
        rdc("second counter", OFS_HIGH_CNT, 32'h3);
        // A rising edge alone must count once more
        pin2 <= 1'b1;
        repeat (6) @(posedge clk);
        rdc("count on rise", OFS_HIGH_CNT, 32'h4);
        tally_and_finish();
    end
endmodule
`default_nettype wire
